/* hw/gpib_defs.svh */
// constants for the instrument bus device interface
`ifndef GPIB_DEFS_SVH
`define GPIB_DEFS_SVH

// system clock period in ns (100 MHz)
`define GPIB_CLK_NS      10
// source settling time before data valid, ns
`define GPIB_T1_NS       2000

// universal commands (low seven bits, attention asserted)
`define GPIB_CMD_LLO     7'h11
`define GPIB_CMD_DCL     7'h14
`define GPIB_CMD_PPU     7'h15
`define GPIB_CMD_SPE     7'h18
`define GPIB_CMD_SPD     7'h19
// addressed commands
`define GPIB_CMD_GTL     7'h01
`define GPIB_CMD_SDC     7'h04
`define GPIB_CMD_PPC     7'h05
`define GPIB_CMD_GET     7'h08
// unlisten / untalk
`define GPIB_CMD_UNL     7'h3f
`define GPIB_CMD_UNT     7'h5f
// command group field (bits 6:5)
`define GPIB_GRP_LSB     5
`define GPIB_GRP_LISTEN  2'b01
`define GPIB_GRP_TALK    2'b10
`define GPIB_GRP_SECOND  2'b11
// parallel poll secondary: bit 4 disable, bit 3 sense, bits 2:0 line
`define GPIB_PPE_DIS_BIT 4
`define GPIB_PPE_SNS_BIT 3
// status byte bit carrying the service request flag
`define GPIB_RSV_BIT     6
// address reserved for unlisten / untalk
`define GPIB_ADDR_NONE   5'h1f

`endif

/* hw/gpib_pkg.sv */
// state types for the instrument bus device interface
package gpib_pkg;

   // acceptor handshake states
   typedef enum logic [4:0] {
      AH_IDLE = 5'b00001,
      AH_NRDY = 5'b00010,
      AH_RDY  = 5'b00100,
      AH_ACPT = 5'b01000,
      AH_WAIT = 5'b10000
   } ah_state_t;

   // source handshake states
   typedef enum logic [2:0] {
      SH_IDLE = 3'b001,
      SH_DLY  = 3'b010,
      SH_TRS  = 3'b100
   } sh_state_t;

endpackage

/* hw/gpib_sync.sv */
// two-stage synchroniser for bus pin inputs
`timescale 1ns/1ns
module gpib_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk_in, // system clock
   input  wire logic         rstn_in,    // sync reset, active low
   input  wire logic [W-1:0] d_in,       // asynchronous pins
   output logic      [W-1:0] q_out       // synchronised levels
);
   logic [W-1:0] meta_r;

   // idle bus lines float high, so reset to ones
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         meta_r <= '1;
         q_out  <= '1;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule

/* hw/gpib_device_interface.sv */
// device side of the instrument bus: handshakes, addressing, polls, remote/local
`timescale 1ns/1ns
`include "gpib_defs.svh"
module gpib_device_interface
   import gpib_pkg::*;
#(
   parameter int SETTLE_NS = `GPIB_T1_NS,
   parameter int CLK_NS    = `GPIB_CLK_NS
) (
   input  wire logic       sys_clk_in,     // 100 MHz system clock
   input  wire logic       rstn_in,        // sync reset, active low
   input  wire logic [4:0] my_addr_in,     // own primary bus address
   // bus pins, open-drain lines drive low when enabled
   input  wire logic [7:0] dio_in,         // data lines
   output logic      [7:0] dio_out,        // data line drive value
   output logic      [7:0] dio_oe_out,     // data line enables
   input  wire logic       ifc_n_in,       // interface clear
   input  wire logic       atn_n_in,       // attention
   input  wire logic       ren_n_in,       // remote enable
   input  wire logic       eoi_n_in,       // end or identify
   output logic            eoi_oe_out,     // pull end or identify low
   output logic            srq_oe_out,     // pull service request low
   input  wire logic       dav_n_in,       // data valid
   output logic            dav_oe_out,     // pull data valid low
   input  wire logic       nrfd_n_in,      // not ready for data
   output logic            nrfd_oe_out,    // pull not ready low
   input  wire logic       ndac_n_in,      // not data accepted
   output logic            ndac_oe_out,    // pull not accepted low
   // received device bytes
   input  wire logic       rx_ready_in,    // user can take a byte
   output logic      [7:0] rx_data_out,    // received byte
   output logic            rx_end_out,     // byte was the last one
   output logic            rx_valid_out,   // one-cycle byte strobe
   // bytes to transmit
   input  wire logic [7:0] tx_data_in,     // byte to send
   input  wire logic       tx_end_in,      // mark byte as last
   input  wire logic       tx_valid_in,    // byte offered
   output logic            tx_ready_out,   // byte taken by the bus
   // status, service and poll
   input  wire logic [7:0] status_in,      // serial poll status byte
   input  wire logic       rsv_in,         // user wants service
   input  wire logic       ist_in,         // parallel poll status bit
   input  wire logic       rtl_in,         // front panel return to local
   // device state
   output logic            listen_out,     // listener addressed
   output logic            talk_out,       // talker addressed
   output logic            remote_out,     // remote operation
   output logic            lockout_out,    // local lockout
   output logic            dev_clear_out,  // one-cycle device clear
   output logic            trigger_out     // one-cycle device trigger
);
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CW         = $clog2(SETTLE_CYC + 1);

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [7:0] dio_s;
   logic ifc_n_s, atn_n_s, ren_n_s, eoi_n_s, dav_n_s, nrfd_n_s, ndac_n_s;

   gpib_sync #(.W(15)) u_sync (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .d_in       ({dio_in, ifc_n_in, atn_n_in, ren_n_in, eoi_n_in,
                    dav_n_in, nrfd_n_in, ndac_n_in}),
      .q_out      ({dio_s, ifc_n_s, atn_n_s, ren_n_s, eoi_n_s,
                    dav_n_s, nrfd_n_s, ndac_n_s})
   );

   ////////////////////////////////////////////////////////////////
   // state registers
   ah_state_t     ah_r, ah_nxt;
   sh_state_t     sh_r, sh_nxt;
   logic [CW-1:0] cnt_r;
   logic          listen_r, talk_r, spms_r, pacs_r;
   logic          ppe_r, pp_sense_r;
   logic [2:0]    pp_line_r;
   logic          remote_r, lockout_r, srq_pend_r, rsv_prev_r;
   logic [7:0]    tx_byte_r, dio_val_r, dio_oe_r;
   logic          tx_eoi_r;
   logic [7:0]    rx_data_r;
   logic          rx_end_r, rx_valid_r, dev_clear_r, trigger_r;

   ////////////////////////////////////////////////////////////////
   // bus condition decode
   wire att      = ~atn_n_s;                  // interface messages
   wire ifc_act  = ~ifc_n_s;
   wire ren_act  = ~ren_n_s;
   wire acc_act  = (att | listen_r) & ~ifc_act;
   wire acc_rdy  = att | rx_ready_in;
   wire acc_take = (ah_r == AH_ACPT);
   wire [6:0] cmd = dio_s[6:0];               // parity bit ignored
   wire [1:0] grp = cmd[`GPIB_GRP_LSB +: 2];
   wire is_cmd   = acc_take & att;
   wire own_addr = (cmd[4:0] == my_addr_in) & (my_addr_in != `GPIB_ADDR_NONE);
   wire mla      = is_cmd & (grp == `GPIB_GRP_LISTEN) & own_addr;
   wire mta      = is_cmd & (grp == `GPIB_GRP_TALK) & own_addr;
   wire ota      = is_cmd & (grp == `GPIB_GRP_TALK) & ~own_addr;
   wire unl      = is_cmd & (cmd == `GPIB_CMD_UNL);
   wire c_llo    = is_cmd & (cmd == `GPIB_CMD_LLO);
   wire c_dcl    = is_cmd & (cmd == `GPIB_CMD_DCL);
   wire c_ppu    = is_cmd & (cmd == `GPIB_CMD_PPU);
   wire c_spe    = is_cmd & (cmd == `GPIB_CMD_SPE);
   wire c_spd    = is_cmd & (cmd == `GPIB_CMD_SPD);
   wire c_gtl    = is_cmd & (cmd == `GPIB_CMD_GTL) & listen_r;
   wire c_sdc    = is_cmd & (cmd == `GPIB_CMD_SDC) & listen_r;
   wire c_ppc    = is_cmd & (cmd == `GPIB_CMD_PPC) & listen_r;
   wire c_get    = is_cmd & (cmd == `GPIB_CMD_GET) & listen_r;
   wire c_sec    = is_cmd & (grp == `GPIB_GRP_SECOND);
   wire c_prim   = is_cmd & (grp != `GPIB_GRP_SECOND);
   wire rx_take  = acc_take & ~att & listen_r;

   ////////////////////////////////////////////////////////////////
   // acceptor handshake next state
   always_comb begin
      ah_nxt = ah_r;
      unique case (ah_r)
         AH_IDLE: if (acc_act) ah_nxt = AH_NRDY;
         AH_NRDY: begin
            if (!acc_act)               ah_nxt = AH_IDLE;
            else if (acc_rdy & dav_n_s) ah_nxt = AH_RDY;
         end
         AH_RDY: begin
            if (!acc_act)     ah_nxt = AH_IDLE;
            else if (!dav_n_s) ah_nxt = AH_ACPT;
            else if (!acc_rdy) ah_nxt = AH_NRDY;
         end
         AH_ACPT: ah_nxt = AH_WAIT;
         AH_WAIT: if (dav_n_s) ah_nxt = acc_act ? AH_NRDY : AH_IDLE;
         default: ah_nxt = AH_IDLE;
      endcase
   end

   // acceptor handshake line drive
   assign nrfd_oe_out = (ah_r == AH_NRDY) | (ah_r == AH_ACPT) | (ah_r == AH_WAIT);
   assign ndac_oe_out = (ah_r == AH_NRDY) | (ah_r == AH_RDY) | (ah_r == AH_ACPT);

   ////////////////////////////////////////////////////////////////
   // source handshake
   wire talk_act = talk_r & ~att & ~ifc_act;
   wire tx_have  = spms_r | tx_valid_in;
   wire settled  = (cnt_r >= CW'(SETTLE_CYC));
   wire tx_done  = (sh_r == SH_TRS) & ndac_n_s;
   wire [7:0] sp_byte = {status_in[7], srq_pend_r, status_in[5:0]};

   // next state of the source handshake
   always_comb begin
      sh_nxt = sh_r;
      unique case (sh_r)
         SH_IDLE: if (talk_act & tx_have) sh_nxt = SH_DLY;
         SH_DLY: begin
            if (!talk_act)                 sh_nxt = SH_IDLE;
            else if (settled & nrfd_n_s)   sh_nxt = SH_TRS;
         end
         SH_TRS: if (!talk_act | ndac_n_s) sh_nxt = SH_IDLE;
         default: sh_nxt = SH_IDLE;
      endcase
   end

   // source line drive: data valid only in the transfer state
   assign dav_oe_out   = (sh_r == SH_TRS);
   assign eoi_oe_out   = (sh_r != SH_IDLE) & tx_eoi_r;
   assign tx_ready_out = tx_done & ~spms_r;
   wire   src_drive    = (sh_r != SH_IDLE);

   ////////////////////////////////////////////////////////////////
   // parallel poll response decode
   wire pp_poll = att & ~eoi_n_s;
   wire pp_resp = pp_poll & ppe_r & (ist_in == pp_sense_r) & ~src_drive;
   wire [7:0] pp_mask = 8'h01 << pp_line_r;

   ////////////////////////////////////////////////////////////////
   // handshake state registers
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         ah_r <= AH_IDLE;
         sh_r <= SH_IDLE;
      end else begin
         ah_r <= ah_nxt;
         sh_r <= sh_nxt;
      end
   end

   // settle counter and outgoing byte latch
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cnt_r     <= '0;
         tx_byte_r <= 8'h00;
         tx_eoi_r  <= 1'b0;
      end else if (sh_r == SH_IDLE) begin
         cnt_r     <= '0;
         tx_byte_r <= spms_r ? sp_byte : tx_data_in;
         tx_eoi_r  <= ~spms_r & tx_end_in;
      end else if (!settled) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // registered data line drive, cleared one cycle after valid drops
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         dio_val_r <= 8'h00;
         dio_oe_r  <= 8'h00;
      end else begin
         dio_val_r <= src_drive ? tx_byte_r : 8'h00;
         dio_oe_r  <= src_drive ? 8'hff : (pp_resp ? pp_mask : 8'h00);
      end
   end
   assign dio_out    = dio_val_r;
   assign dio_oe_out = dio_oe_r;

   ////////////////////////////////////////////////////////////////
   // listener and talker addressing, serial poll mode
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in | ifc_act) begin
         listen_r <= 1'b0;
         talk_r   <= 1'b0;
         spms_r   <= 1'b0;
      end else begin
         if (mla)            listen_r <= 1'b1;
         else if (unl | mta) listen_r <= 1'b0;
         if (mta)            talk_r <= 1'b1;
         else if (ota | mla | (is_cmd & cmd == `GPIB_CMD_UNT))
            talk_r <= 1'b0;
         if (c_spe)      spms_r <= 1'b1;
         else if (c_spd) spms_r <= 1'b0;
      end
   end

   // parallel poll configuration
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         pacs_r     <= 1'b0;
         ppe_r      <= 1'b0;
         pp_sense_r <= 1'b0;
         pp_line_r  <= 3'h0;
      end else begin
         if (ifc_act)     pacs_r <= 1'b0;
         else if (c_ppc)  pacs_r <= 1'b1;
         else if (c_prim) pacs_r <= 1'b0;
         if (c_ppu) ppe_r <= 1'b0;
         else if (c_sec & pacs_r) begin
            ppe_r      <= ~cmd[`GPIB_PPE_DIS_BIT];
            pp_sense_r <= cmd[`GPIB_PPE_SNS_BIT];
            pp_line_r  <= cmd[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // remote/local with lockout, both dropped while remote enable is released
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in | !ren_act) begin
         remote_r  <= 1'b0;
         lockout_r <= 1'b0;
      end else begin
         if (mla)                         remote_r <= 1'b1;
         else if (c_gtl)                  remote_r <= 1'b0;
         else if (rtl_in & ~lockout_r)    remote_r <= 1'b0;
         if (c_llo)                       lockout_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // service request: rising request sets, polled status clears
   wire srq_clr = tx_done & spms_r & tx_byte_r[`GPIB_RSV_BIT];
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         srq_pend_r <= 1'b0;
         rsv_prev_r <= 1'b0;
      end else begin
         rsv_prev_r <= rsv_in;
         if (rsv_in & ~rsv_prev_r) srq_pend_r <= 1'b1;
         else if (srq_clr)         srq_pend_r <= 1'b0;
      end
   end
   assign srq_oe_out = srq_pend_r;

   ////////////////////////////////////////////////////////////////
   // received bytes and command strobes
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         rx_data_r   <= 8'h00;
         rx_end_r    <= 1'b0;
         rx_valid_r  <= 1'b0;
         dev_clear_r <= 1'b0;
         trigger_r   <= 1'b0;
      end else begin
         rx_valid_r  <= rx_take;
         if (rx_take) begin
            rx_data_r <= dio_s;
            rx_end_r  <= ~eoi_n_s;
         end
         dev_clear_r <= c_dcl | c_sdc;
         trigger_r   <= c_get;
      end
   end

   assign rx_data_out   = rx_data_r;
   assign rx_end_out    = rx_end_r;
   assign rx_valid_out  = rx_valid_r;
   assign dev_clear_out = dev_clear_r;
   assign trigger_out   = trigger_r;
   assign listen_out    = listen_r;
   assign talk_out      = talk_r;
   assign remote_out    = remote_r;
   assign lockout_out   = lockout_r;

   ////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);

   a_dav_with_data:  assert property (dav_oe_out |-> dio_oe_out == 8'hff)
      else $error("data valid without data drive");
   a_dav_after_rdy:  assert property ($rose(dav_oe_out) |-> $past(nrfd_n_s) && $past(settled))
      else $error("data valid before ready or settle");
   a_dav_release:    assert property (dav_oe_out && ndac_n_s |=> !dav_oe_out)
      else $error("data valid held after accept");
   a_ifc_default:    assert property (ifc_act |=> !listen_r && !talk_r && !spms_r)
      else $error("interface clear left function addressed");
   a_mta_unlisten:   assert property (mta |=> talk_r && !listen_r)
      else $error("own talk address kept listener");
   a_mla_untalk:     assert property (mla |=> listen_r && !talk_r)
      else $error("own listen address kept talker");
   a_ndac_accept:    assert property (acc_take |-> ndac_oe_out && nrfd_oe_out ##1 !ndac_oe_out)
      else $error("accept sequence wrong");
   a_remote_ren:     assert property ($rose(remote_r) |-> $past(ren_act))
      else $error("remote entered without remote enable");
   a_srq_rise:       assert property ($rose(rsv_in) |=> ##1 srq_oe_out)
      else $error("service request not driven");
   a_rx_byte:        assert property (rx_take |=> rx_valid_out && rx_data_out == $past(dio_s)
                                      && rx_end_out == !$past(eoi_n_s))
      else $error("received byte or end flag wrong");
   a_cmd_not_data:   assert property (is_cmd |=> !rx_valid_out)
      else $error("command passed as device data");
   a_pp_drive:       assert property (pp_resp |=> dio_oe_out == $past(pp_mask))
      else $error("parallel poll line not driven");
   a_clear_pulse:    assert property (c_dcl |=> dev_clear_out ##1 !dev_clear_out)
      else $error("device clear pulse wrong");
   a_trig_pulse:     assert property (c_get |=> trigger_out)
      else $error("trigger not raised");

   c_rx_data:   cover property (rx_take ##1 rx_valid_out);
   c_tx_byte:   cover property (tx_ready_out);
   c_ser_poll:  cover property (srq_clr);
   c_par_poll:  cover property (pp_resp);
endmodule

/* test/gpib_ctrl_model.sv */
// behavioural bus controller and listener facing the device
`timescale 1ns/1ns
module gpib_ctrl_model (
   input  wire logic       clk_in,        // system clock
   input  wire logic [7:0] dio_in,        // resolved data lines
   input  wire logic       eoi_n_in,      // resolved end or identify
   input  wire logic       dav_n_in,      // resolved data valid
   input  wire logic       nrfd_n_in,     // resolved not ready
   input  wire logic       ndac_n_in,     // resolved not accepted
   output logic            atn_out,       // pull attention low
   output logic            eoi_out,       // pull end or identify low
   output logic            dav_out,       // pull data valid low
   output logic            nrfd_out,      // pull not ready low
   output logic            ndac_out,      // pull not accepted low
   output logic            d_oe_out,      // drive data lines
   output logic      [7:0] d_out,         // data drive value
   output logic      [8:0] got_out,       // accepted byte with end flag
   output logic            got_valid_out  // one-cycle accept strobe
);
   // idle as a listener that is not ready
   initial begin
      {atn_out, eoi_out, dav_out, d_oe_out, got_valid_out} = 5'h00;
      {nrfd_out, ndac_out} = 2'b11;
      d_out = 8'h00;
      got_out = 9'h000;
   end

   // set attention and end or identify levels
   task automatic hold(input logic atn, input logic eoi);
      atn_out <= atn;
      eoi_out <= eoi;
      @(posedge clk_in);
   endtask

   // source one byte, interlocked with every acceptor
   task automatic send(input logic atn, input logic [7:0] b, input logic eoi);
      atn_out <= atn;
      nrfd_out <= 1'b0;
      ndac_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      while (nrfd_n_in !== 1'b1) @(posedge clk_in);
      d_oe_out <= 1'b1;
      d_out <= b;
      eoi_out <= eoi;
      repeat (4) @(posedge clk_in);
      dav_out <= 1'b1;
      @(posedge clk_in);
      while (ndac_n_in !== 1'b1) @(posedge clk_in);
      dav_out <= 1'b0;
      @(posedge clk_in);
      d_oe_out <= 1'b0;
      eoi_out <= 1'b0;
      {nrfd_out, ndac_out} <= 2'b11;
      @(posedge clk_in);
   endtask

   // accept one byte from the talker and report it
   task automatic recv();
      atn_out <= 1'b0;
      nrfd_out <= 1'b0;
      @(posedge clk_in);
      while (dav_n_in !== 1'b0) @(posedge clk_in);
      nrfd_out <= 1'b1;
      got_out <= {~eoi_n_in, dio_in};
      got_valid_out <= 1'b1;
      @(posedge clk_in);
      got_valid_out <= 1'b0;
      ndac_out <= 1'b0;
      while (dav_n_in !== 1'b1) @(posedge clk_in);
      ndac_out <= 1'b1;
      @(posedge clk_in);
   endtask
endmodule

/* test/tb.sv */
// self-checking bench for the instrument bus device interface
`timescale 1ns/1ns
`include "gpib_defs.svh"
module tb;
   logic       sys_clk_in, rstn_in, ifc_p, ren_p, rx_ready, tx_valid, tx_end, rsv, ist, rtl;
   logic [4:0] addr;
   logic [7:0] status, tx_data, dio_out, dio_oe, m_d, b;
   logic       eoi_oe, srq_oe, dav_oe, nrfd_oe, ndac_oe, rx_end, rx_valid, tx_ready;
   logic       listen, talk, remote, lockout, dev_clear, trigger;
   logic       m_atn, m_eoi, m_dav, m_nrfd, m_ndac, m_doe, got_v;
   logic [7:0] rx_data, dio_w;
   logic [8:0] got;
   logic [3:0] n_trig, n_clr;
   logic [8:0] rx_q[$], tx_q[$];
   int         fail_count, checked;
   wire        atn_w = ~m_atn;
   wire        eoi_w = ~(m_eoi | eoi_oe);
   wire        dav_w = ~(m_dav | dav_oe);
   wire        nrfd_w = ~(m_nrfd | nrfd_oe);
   wire        ndac_w = ~(m_ndac | ndac_oe);

   // open-drain data lines with pull-ups
   assign dio_w = ~((dio_oe & ~dio_out) | ({8{m_doe}} & ~m_d));

   gpib_device_interface #(.SETTLE_NS(50), .CLK_NS(10)) uut (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .my_addr_in(addr), .dio_in(dio_w),
      .dio_out(dio_out), .dio_oe_out(dio_oe), .ifc_n_in(~ifc_p), .atn_n_in(atn_w),
      .ren_n_in(~ren_p), .eoi_n_in(eoi_w), .eoi_oe_out(eoi_oe), .srq_oe_out(srq_oe),
      .dav_n_in(dav_w), .dav_oe_out(dav_oe), .nrfd_n_in(nrfd_w), .nrfd_oe_out(nrfd_oe),
      .ndac_n_in(ndac_w), .ndac_oe_out(ndac_oe), .rx_ready_in(rx_ready), .rx_data_out(rx_data),
      .rx_end_out(rx_end), .rx_valid_out(rx_valid), .tx_data_in(tx_data), .tx_end_in(tx_end),
      .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .status_in(status), .rsv_in(rsv),
      .ist_in(ist), .rtl_in(rtl), .listen_out(listen), .talk_out(talk), .remote_out(remote),
      .lockout_out(lockout), .dev_clear_out(dev_clear), .trigger_out(trigger));

   gpib_ctrl_model m (
      .clk_in(sys_clk_in), .dio_in(dio_w), .eoi_n_in(eoi_w), .dav_n_in(dav_w),
      .nrfd_n_in(nrfd_w), .ndac_n_in(ndac_w), .atn_out(m_atn), .eoi_out(m_eoi),
      .dav_out(m_dav), .nrfd_out(m_nrfd), .ndac_out(m_ndac), .d_oe_out(m_doe),
      .d_out(m_d), .got_out(got), .got_valid_out(got_v));

   // compare one value and count it
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // report counts and end the run
   task automatic complete_run();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // result watchers take the oldest note per result
   always @(posedge sys_clk_in) begin
      if (rx_valid === 1'b1 && atn_w === 1'b1) chk({rx_end, rx_data}, rx_q.pop_front());
      if (got_v === 1'b1) chk(got, tx_q.pop_front());
      if (trigger === 1'b1) n_trig <= n_trig + 4'h1;
      if (dev_clear === 1'b1) n_clr <= n_clr + 4'h1;
   end

   // watchdog
   initial begin
      #500000;
      fail_count++;
      complete_run();
   end

   // main sequence
   initial begin
      {rstn_in, ifc_p, ren_p, tx_valid, tx_end, rsv, ist, rtl} = 8'h00;
      rx_ready = 1'b1;
      {status, tx_data, n_trig, n_clr} = 24'h000000;
      fail_count = 0;
      checked = 0;
      void'($urandom(88));
      addr = 5'($urandom_range(30));
      repeat (8) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      ren_p <= 1'b1;
      status <= 8'($urandom);
      repeat (4) @(posedge sys_clk_in);
      chk({dav_oe, nrfd_oe, ndac_oe, srq_oe, listen, talk, remote, lockout, trigger}, 9'h000);
      m.send(1'b1, {3'b001, addr}, 1'b0);
      chk({6'h00, listen, talk, remote}, 9'h005);
      // front panel return to local without lockout
      rtl <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      chk({8'h00, remote}, 9'h000);
      rtl <= 1'b0;
      m.send(1'b1, {3'b001, addr}, 1'b0);
      m.send(1'b1, {1'b0, `GPIB_CMD_LLO}, 1'b0);
      // lockout blocks the front panel, go to local still works
      rtl <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      chk({7'h00, lockout, remote}, 9'h003);
      rtl <= 1'b0;
      m.send(1'b1, {1'b0, `GPIB_CMD_GTL}, 1'b0);
      chk({7'h00, lockout, remote}, 9'h002);
      m.send(1'b1, {1'b0, `GPIB_CMD_GET}, 1'b0);
      m.send(1'b1, {1'b0, `GPIB_CMD_SDC}, 1'b0);
      m.send(1'b1, {1'b0, `GPIB_CMD_DCL}, 1'b0);
      chk({1'b0, n_trig, n_clr}, 9'h012);
      m.send(1'b1, {1'b0, `GPIB_CMD_PPC}, 1'b0);
      m.send(1'b1, 8'h6b, 1'b0);
      ist <= 1'b1;
      m.hold(1'b1, 1'b1);
      repeat (6) @(posedge sys_clk_in);
      chk({dio_w[3], dio_oe}, 9'h008);
      ist <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      chk({1'b0, dio_oe}, 9'h000);
      m.hold(1'b0, 1'b0);
      rx_ready <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      chk({8'h00, nrfd_oe}, 9'h001);
      rx_ready <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom);
         rx_q.push_back({i == 3, b});
         m.send(1'b0, b, i == 3);
      end
      m.send(1'b1, {3'b010, addr}, 1'b0);
      chk({7'h00, listen, talk}, 9'h001);
      tx_data <= 8'($urandom);
      tx_end <= 1'b1;
      tx_valid <= 1'b1;
      @(posedge sys_clk_in);
      tx_q.push_back({1'b1, tx_data});
      fork
         m.recv();
         begin
            while (tx_ready !== 1'b1) @(posedge sys_clk_in);
            tx_valid <= 1'b0;
         end
      join
      rsv <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      chk({8'h00, srq_oe}, 9'h001);
      m.send(1'b1, {1'b0, `GPIB_CMD_SPE}, 1'b0);
      tx_q.push_back({1'b0, status[7], 1'b1, status[5:0]});
      m.recv();
      repeat (4) @(posedge sys_clk_in);
      chk({8'h00, srq_oe}, 9'h000);
      m.send(1'b1, {1'b0, `GPIB_CMD_SPD}, 1'b0);
      ifc_p <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      ifc_p <= 1'b0;
      chk({7'h00, listen, talk}, 9'h000);
      ren_p <= 1'b0;
      repeat (5) @(posedge sys_clk_in);
      chk({7'h00, remote, lockout}, 9'h000);
      chk(9'(rx_q.size() + tx_q.size()), 9'h000);
      complete_run();
   end
endmodule
